// ---- inc/tmw_pkg.sv ----
package tmw_pkg;
	// Register word indices, byte address is four times the index
	localparam logic [3:0] IDX_PIN_SELECT = 4'h0;
	localparam logic [3:0] IDX_TRIP_ONE = 4'h1;
	localparam logic [3:0] IDX_TRIP_TWO = 4'h2;
	localparam logic [3:0] IDX_TRIP_THREE = 4'h3;
	localparam logic [3:0] IDX_HW_COMPARE = 4'h4;
	localparam int REG_COUNT = 5;
	localparam int ADDR_W = 6;
	// Field positions
	localparam int BIT_QUALIFY = 14;
	localparam int BIT_GREATER = 13;
	localparam int BIT_RELAY = 8;
	localparam int PIN_LSB = 0;
	localparam int PIN_MSB = 7;
	localparam int CTRL_LSB = 8;
	localparam int CTRL_MSB = 13;
	// Reset values
	localparam logic [15:0] RESET_WORD = 16'h0000;
	// Masks derived from the field positions
	localparam logic [15:0] MASK_PIN = 16'h00ff;
	localparam logic [15:0] MASK_CTRL = 16'h3f00;
	localparam logic [15:0] MASK_LOW14 = 16'h3fff;
	localparam logic [15:0] MASK_QUAL = 16'h4000;
	typedef enum logic [1:0] {
		TMW_BUS_IDLE,
		TMW_BUS_ACK
	} tmw_bus_state_t;
endpackage : tmw_pkg

// ---- inc/tmw_reg_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Write port and read port of the register store
interface tmw_reg_if;
	logic wr_en;
	logic [2:0] wr_idx;
	logic [15:0] wr_data;
	logic [2:0] rd_idx;
	logic [15:0] rd_data;
	modport ctrl (output wr_en, output wr_idx, output wr_data,
		output rd_idx, input rd_data);
	modport store (input wr_en, input wr_idx, input wr_data,
		input rd_idx, output rd_data);
endinterface : tmw_reg_if
`default_nettype wire

// ---- design/tmw_reg_store.sv ----
`timescale 1ns/100ps
`default_nettype none
// Small register memory with registered read data
module tmw_reg_store #(
	parameter int DEPTH = 5
) (
	input wire logic clk,
	input wire logic sys_rst,
	tmw_reg_if.store port
);
	import tmw_pkg::*;
	logic [15:0] mem [DEPTH];

	// Word storage; the controller hands in an already merged word
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= RESET_WORD;
			end
		end else if (port.wr_en && (int'(port.wr_idx) < DEPTH)) begin
			mem[port.wr_idx] <= port.wr_data;
		end
	end

	// Read data registered, so one cycle of latency
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			port.rd_data <= RESET_WORD;
		end else if (int'(port.rd_idx) < DEPTH) begin
			port.rd_data <= mem[port.rd_idx];
		end else begin
			port.rd_data <= RESET_WORD;
		end
	end
endmodule : tmw_reg_store
`default_nettype wire

// ---- design/tmw_mode_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [RL1] Trip register bit 14 one gives current force, zero gives voltage force.
// [RL2] Trip register bit 13 one gives greater-than compare, zero less-than.
// [RL3] Pin select write with bit 14 clear updates only pin bits 0-7.
// [RL4] Pin select write with bit 14 set updates bits 8-13, ignores pin data.
// [RL5] Software sets bit 14 when it wants relay bit 8 changed.
// [RL6] Pin select bit 8 one closes the voltage conditioner relay.
// [RL7] Qualified write leaving bit 8 zero disconnects unit from pin driver.
// [RL8] Bit 14 is the strobe or current-force qualifier across registers.
// [RL9] Bit 13 carries greater-than option, except bit 8 on pin select.
// [RL10] Hardware compare write with strobe bit 14 keeps bits 0-13.
// [RL11] Bits not updated keep their values; read back gives merged word.
module tmw_mode_bank (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [tmw_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [7:0] pin_number,
	output logic relay_closed,
	output logic unit_disconnected,
	output logic [2:0] trip_current_force,
	output logic [2:0] trip_greater_than,
	output logic compare_greater_than,
	output logic compare_strobe_option
);
	import tmw_pkg::*;

	tmw_reg_if rif ();
	tmw_bus_state_t state;
	logic [15:0] cur;
	logic [15:0] next_word;
	logic [15:0] wmask;
	logic [15:0] lane_data;
	logic valid_idx;
	logic [2:0] idx;

	tmw_reg_store #(.DEPTH(REG_COUNT)) u_store (
		.clk(clk),
		.sys_rst(sys_rst),
		.port(rif.store)
	);

	// Merge a written word into the stored one under the field mask
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] data, input logic [15:0] m);
		merge = (old & ~m) | (data & m);
	endfunction : merge

	// Word index decode; bits above the index read as an unmapped address
	assign idx = wb_adr_i[4:2];
	assign valid_idx = (wb_adr_i[ADDR_W-1] == 1'b0) &&
		(int'(wb_adr_i[4:2]) < REG_COUNT);
	assign rif.rd_idx = idx;
	assign cur = rif.rd_data;

	// Byte lanes: only the two low lanes hold data, upper lanes ignored
	always_comb begin
		lane_data = cur;
		if (wb_sel_i[0]) begin
			lane_data[7:0] = wb_dat_i[7:0];
		end
		if (wb_sel_i[1]) begin
			lane_data[15:8] = wb_dat_i[15:8];
		end
	end

	// Field mask picked by register and by the qualifier bit
	always_comb begin
		wmask = 16'hffff;
		if (idx == IDX_PIN_SELECT[2:0]) begin
			if (lane_data[BIT_QUALIFY]) begin
				wmask = MASK_CTRL; // see [RL4] see [RL5] see [RL9]
			end else begin
				wmask = MASK_PIN; // see [RL3]
			end
		end else if (idx == IDX_HW_COMPARE[2:0]) begin
			if (lane_data[BIT_QUALIFY]) begin
				wmask = MASK_QUAL; // see [RL10] see [RL8]
			end
		end
		next_word = merge(cur, lane_data, wmask); // see [RL11]
	end

	// Bus handshake: wait one cycle for registered read data, then ack
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= TMW_BUS_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			case (state)
				TMW_BUS_IDLE: begin
					wb_ack_o <= 1'b0;
					if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
						state <= TMW_BUS_ACK;
					end
				end
				TMW_BUS_ACK: begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= valid_idx ? {16'h0000, cur} : 32'h0000_0000;
					state <= TMW_BUS_IDLE;
				end
				default: begin
					state <= TMW_BUS_IDLE;
				end
			endcase
		end
	end

	// Store write in the ack cycle, using read data of the held address
	assign rif.wr_en = (state == TMW_BUS_ACK) && wb_we_i && valid_idx &&
		wb_cyc_i && wb_stb_i;
	assign rif.wr_idx = idx;
	assign rif.wr_data = next_word;

	// Pin select decode; disconnect only follows a qualified write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_number <= 8'h00;
			relay_closed <= 1'b0;
			unit_disconnected <= 1'b0;
		end else if (rif.wr_en && idx == IDX_PIN_SELECT[2:0]) begin
			pin_number <= next_word[PIN_MSB:PIN_LSB];
			relay_closed <= next_word[BIT_RELAY]; // see [RL6]
			if (lane_data[BIT_QUALIFY]) begin
				unit_disconnected <= ~next_word[BIT_RELAY]; // see [RL7]
			end
		end
	end

	// Trip register modes, one bit pair for each supply
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trip_current_force <= 3'h0;
			trip_greater_than <= 3'h0;
		end else if (rif.wr_en) begin
			for (int t = 0; t < 3; t++) begin
				if (int'(idx) == int'(IDX_TRIP_ONE) + t) begin
					trip_current_force[t] <= next_word[BIT_QUALIFY]; // see [RL1]
					trip_greater_than[t] <= next_word[BIT_GREATER]; // see [RL2]
				end
			end
		end
	end

	// Hardware compare mode bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			compare_greater_than <= 1'b0;
			compare_strobe_option <= 1'b0;
		end else if (rif.wr_en && idx == IDX_HW_COMPARE[2:0]) begin
			compare_greater_than <= next_word[BIT_GREATER]; // see [RL9]
			compare_strobe_option <= next_word[BIT_QUALIFY]; // see [RL8]
		end
	end
endmodule : tmw_mode_bank
`default_nettype wire

// ---- verif/tmw_mode_bank_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// Judges each full low-half write to a mapped register in its answer cycle, while the request still stands
module tmw_mode_bank_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_we_i,
	input wire logic [tmw_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic [7:0] pin_number,
	input wire logic relay_closed,
	input wire logic unit_disconnected,
	input wire logic [2:0] trip_current_force,
	input wire logic [2:0] trip_greater_than,
	input wire logic compare_greater_than,
	input wire logic compare_strobe_option
);
	import tmw_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Full low-half write answered at one address
	function automatic logic wr(input logic [5:0] a);
		return wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'h3 && wb_adr_i == a;
	endfunction : wr
	trip_force_a: assert property (wr(6'h04) |->
		trip_current_force[0] == wb_dat_i[14]) else $error("trip force");
	trip_greater_a: assert property (wr(6'h08) |->
		trip_greater_than[1] == wb_dat_i[13]) else $error("trip compare");
	trip_qual_a: assert property (wr(6'h0c) |->
		trip_current_force[2] == wb_dat_i[14]) else $error("trip qualifier");
	pin_only_a: assert property (wr(6'h00) && !wb_dat_i[14] |->
		pin_number == wb_dat_i[7:0] && $stable(relay_closed)
		&& $stable(unit_disconnected)) else $error("pin write");
	pin_keep_a: assert property (wr(6'h00) && wb_dat_i[14] |->
		$stable(pin_number)) else $error("pin kept");
	relay_set_a: assert property (wr(6'h00) && wb_dat_i[14] |->
		relay_closed == wb_dat_i[8]) else $error("relay");
	unit_off_a: assert property (wr(6'h00) && wb_dat_i[14] |->
		unit_disconnected == !wb_dat_i[8]) else $error("disconnect");
	cmp_mode_a: assert property (wr(6'h10) && !wb_dat_i[14] |->
		compare_greater_than == wb_dat_i[13]) else $error("compare mode");
	cmp_strobe_a: assert property (wr(6'h10) && wb_dat_i[14] |->
		compare_strobe_option && $stable(compare_greater_than))
		else $error("compare strobe");
	cover property (wr(6'h00) && wb_dat_i[14]);
	cover property (wr(6'h10) && wb_dat_i[14]);
	cover property (wb_ack_o && !wb_we_i);
endmodule : tmw_mode_bank_chk
bind tmw_mode_bank tmw_mode_bank_chk chk_i (.clk, .sys_rst, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .pin_number, .relay_closed,
	.unit_disconnected, .trip_current_force, .trip_greater_than,
	.compare_greater_than, .compare_strobe_option);
`default_nettype wire

// ---- verif/test_tmw_mode_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_tmw_mode_bank;
	logic clk = 0, sys_rst = 1, cyc = 0, we = 0, ack, rly, dis, cg, cs;
	logic [5:0] adr = 6'h00;
	logic [3:0] sel = 4'h3;
	logic [31:0] wd = 32'h0, rd, q, outs;
	logic [7:0] pin;
	logic [2:0] cf, gt;
	int mismatches = 0, n_tests = 0;
	tmw_mode_bank dut (.clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_ack_o(ack), .pin_number(pin), .relay_closed(rly),
		.unit_disconnected(dis), .trip_current_force(cf),
		.trip_greater_than(gt), .compare_greater_than(cg),
		.compare_strobe_option(cs));
	// All mode outputs packed: pin 7:0, relay 8, off 9, force 12:10,
	// greater 15:13, compare greater 16, strobe 17
	assign outs = {14'h0000, cs, cg, gt, cf, dis, rly, pin};
	initial forever #10 clk = ~clk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	// Request held until ack is sampled; no cycle count is assumed
	task bus(input logic [5:0] a, input logic w, input logic [15:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
	endtask : bus
	task rc(input logic [5:0] a, input logic [15:0] e);
		bus(a, 1'b0, 16'h0000);
		chk(q, {16'h0000, e});
	endtask : rc
	task test_done;
		$display("%0d checks, %0d mismatches", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 5; i++) rc(6'(4 * i), 16'h0000);
		chk(outs, 32'h0);
		$display("test reset done");
		bus(6'h04, 1'b1, 16'h4000);
		bus(6'h08, 1'b1, 16'h2000);
		bus(6'h0c, 1'b1, 16'h6000);
		chk(outs, 32'h0000d400);
		rc(6'h0c, 16'h6000);
		$display("test trip done");
		// Qualified word carries pin data that must be dropped
		bus(6'h00, 1'b1, 16'h7fa5);
		rc(6'h00, 16'h3f00);
		chk(outs, 32'h0000d500);
		bus(6'h00, 1'b1, 16'h3e5a);
		rc(6'h00, 16'h3f5a);
		chk(outs, 32'h0000d55a);
		bus(6'h00, 1'b1, 16'h4000);
		rc(6'h00, 16'h005a);
		chk(outs, 32'h0000d65a);
		$display("test pin done");
		bus(6'h10, 1'b1, 16'h2123);
		rc(6'h10, 16'h2123);
		bus(6'h10, 1'b1, 16'h5fff);
		rc(6'h10, 16'h6123);
		chk(outs, 32'h0003d65a);
		$display("test compare done");
		// Address bit 5 must not alias onto the trip registers
		bus(6'h24, 1'b1, 16'hffff);
		rc(6'h24, 16'h0000);
		rc(6'h14, 16'h0000);
		rc(6'h04, 16'h4000);
		// Low lane only: the upper byte of trip one must survive
		sel <= 4'h1;
		bus(6'h04, 1'b1, 16'h20ff);
		sel <= 4'h3;
		rc(6'h04, 16'h40ff);
		chk(outs, 32'h0003d65a);
		$display("test unmapped done");
		test_done;
	end
	// About 25 transfers of four cycles each; far more is a hang
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		test_done;
	end
endmodule : test_tmw_mode_bank
`default_nettype wire
